// ===== design/rss_regs.svh
// constants and timing counts of the relay scan sequencer
// Functional notes
// RULE_01 - after relay closed and slot delay elapsed, emit ready pulse on external port
// RULE_02 - one settle delay per slot, 0 to 9.999 s, shared by its channels
// RULE_03 - scan list may be a consecutive range from start to end channel
// RULE_04 - scan list may be explicit channels stepped in listed order
// RULE_05 - channel address is slot times one hundred plus two-digit index
// RULE_06 - step trigger only, default; each trigger advances exactly one step
// RULE_07 - idle at list start, first trigger closes first listed channel
// RULE_08 - later triggers open current channel and close the next one
// RULE_09 - on final channel, next trigger completes, opens all, rewinds list
// RULE_10 - after completion a further trigger starts a new pass
// RULE_11 - ready pulse width programmable 0.001 to 0.100 s
// RULE_12 - next channel closing ends a ready pulse at once
// RULE_13 - abort stops scan and rewinds list to first entry
// RULE_14 - after any stop every channel relay is left open
// RULE_15 - while scanning reject setting changes and direct close commands
// RULE_16 - after abort or reset a scan input edge is a valid start
// RULE_17 - instrument runs external trigger, measures per pulse, returns measure_done
// RULE_18 - scan reset pulse stops scan, opens relays, rewinds list
// RULE_19 - ready pulse width defaults to five milliseconds
// RULE_20 - one millisecond tick from sys_clk counts delay and pulse width
// RULE_21 - scan input is rising-edge sensitive, one edge one trigger
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
`define RSS_CLK_MHZ        250
`define RSS_TICK_MS        1
`define RSS_TICK_CYCLES    (`RSS_CLK_MHZ * 1000 * `RSS_TICK_MS)
`define RSS_DELAY_MAX_MS   9999
`define RSS_PULSE_MIN_MS   1
`define RSS_PULSE_MAX_MS   100
`define RSS_PULSE_DEF_MS   7'h05
`define RSS_CH_PER_SLOT    100
`endif

// ===== design/rss_pkg.sv
// types of the relay scan sequencer
package rss_pkg;
    typedef enum logic [2:0] {
        RSS_IDLE,
        RSS_CLOSE_WAIT,
        RSS_SETTLE,
        RSS_PULSE,
        RSS_HOLD
    } rss_state_t;
endpackage : rss_pkg

// ===== design/rss_list_mem.sv
// scan list storage with registered read data
`timescale 1ns/100ps
module rss_list_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 11
) (
    // clock
    input  wire logic          sys_clk,
    // write
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : rss_list_mem

// ===== design/rss_tick_gen.sv
// one millisecond tick from the system clock
`timescale 1ns/100ps
`include "rss_regs.svh"
module rss_tick_gen #(
    parameter int TICK_CYCLES = `RSS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_sync_n,
    // tick
    output logic      tick_ms
);
    logic [31:0] cnt_ff;

    // free running so every ms count may be short by up to one tick
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_ff  <= 32'h0;
            tick_ms <= 1'b0;
        end else if (cnt_ff >= 32'(TICK_CYCLES - 1)) begin
            cnt_ff  <= 32'h0;
            tick_ms <= 1'b1; // RULE_20
        end else begin
            cnt_ff  <= cnt_ff + 32'h1;
            tick_ms <= 1'b0;
        end
    end
endmodule : rss_tick_gen

// ===== design/rss_scan_seq.sv
// relay scan sequencer top
`timescale 1ns/100ps
`include "rss_regs.svh"
module rss_scan_seq
    import rss_pkg::*;
#(
    parameter int TICK_CYCLES = `RSS_TICK_CYCLES,
    parameter int SLOTS       = 12,
    parameter int LIST_DEPTH  = 64,
    parameter int LAW         = 6
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // external io port
    input  wire logic            measure_done,
    input  wire logic            scan_reset,
    output logic                 ready_pulse,
    // host commands
    input  wire logic            trig_cmd,
    input  wire logic            abort_cmd,
    input  wire logic            range_load,
    input  wire logic [10:0]     range_start,
    input  wire logic [10:0]     range_end,
    input  wire logic            list_clear,
    input  wire logic            list_append,
    input  wire logic [10:0]     list_chan,
    input  wire logic            delay_wr,
    input  wire logic [3:0]      delay_slot,
    input  wire logic [13:0]     delay_ms,
    input  wire logic            pulse_wr,
    input  wire logic [6:0]      pulse_ms,
    input  wire logic            close_cmd,
    input  wire logic            cfg_cmd,
    output logic                 cmd_reject,
    // relay drive
    output logic                 relay_close,
    output logic [10:0]          relay_chan,
    input  wire logic            relay_closed,
    // status
    output logic                 scan_active,
    output logic [LAW:0]         list_len
);
    // ----------------------------------------------------------
    // reset release
    // ----------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_n  <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_n  <= rst_meta_ff;
        end
    end

    logic tick_ms;
    rss_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .tick_ms    (tick_ms)
    );

    // ----------------------------------------------------------
    // trigger detection
    // ----------------------------------------------------------
    logic done_meta_ff;
    logic done_sync_ff;
    logic done_prev_ff;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_meta_ff <= 1'b0;
            done_sync_ff <= 1'b0;
            done_prev_ff <= 1'b0;
        end else begin
            done_meta_ff <= measure_done;
            done_sync_ff <= done_meta_ff;
            done_prev_ff <= done_sync_ff;
        end
    end
    logic done_rise;
    logic trig;
    logic stop_req;
    assign done_rise = done_sync_ff & ~done_prev_ff; // RULE_21
    assign trig      = done_rise | trig_cmd; // RULE_06 RULE_16
    assign stop_req  = abort_cmd | scan_reset;

    // ----------------------------------------------------------
    // configuration
    // ----------------------------------------------------------
    rss_state_t    state_ff;
    logic [13:0]   slot_delay_ff [SLOTS];
    logic [6:0]    pulse_w_ff;
    logic          busy;
    assign busy        = (state_ff != RSS_IDLE);
    assign scan_active = busy;
    assign cmd_reject  = busy & (cfg_cmd | close_cmd | delay_wr | pulse_wr | range_load
                                 | list_clear | list_append); // RULE_15

    genvar gs;
    generate
        for (gs = 0; gs < SLOTS; gs++) begin : g_slot
            always_ff @(posedge sys_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    slot_delay_ff[gs] <= 14'h0;
                end else if (!busy && delay_wr && delay_slot == 4'(gs + 1)
                             && delay_ms <= 14'(`RSS_DELAY_MAX_MS)) begin
                    slot_delay_ff[gs] <= delay_ms; // RULE_02
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pulse_w_ff <= `RSS_PULSE_DEF_MS; // RULE_19
        end else if (!busy && pulse_wr && pulse_ms >= 7'(`RSS_PULSE_MIN_MS)
                     && pulse_ms <= 7'(`RSS_PULSE_MAX_MS)) begin
            pulse_w_ff <= pulse_ms; // RULE_11
        end
    end

    // ----------------------------------------------------------
    // scan list
    // ----------------------------------------------------------
    // ranges expand one entry per cycle into the list memory
    logic          fill_ff;
    logic [10:0]   fill_ch_ff;
    logic [10:0]   fill_end_ff;
    logic [LAW:0]  len_ff;
    logic [LAW-1:0] pos_ff;
    logic          wr_en;
    logic [10:0]   wr_data;
    logic [10:0]   list_rd;
    logic          len_full;
    assign len_full = (len_ff == (LAW+1)'(LIST_DEPTH));
    assign wr_en    = !len_full && (fill_ff || (!busy && list_append));
    assign wr_data  = fill_ff ? fill_ch_ff : list_chan;
    assign list_len = len_ff;

    function automatic logic [10:0] next_chan(input logic [10:0] ch);
        logic [10:0] n;
        n = ch + 11'h1;
        if (n % 11'(`RSS_CH_PER_SLOT) == 11'h0) begin
            n = n + 11'h1; // RULE_05
        end
        return n;
    endfunction : next_chan

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fill_ff     <= 1'b0;
            fill_ch_ff  <= 11'h0;
            fill_end_ff <= 11'h0;
            len_ff      <= '0;
        end else if (!busy && (range_load || list_clear)) begin
            fill_ff     <= range_load; // RULE_03
            fill_ch_ff  <= range_start;
            fill_end_ff <= range_end;
            len_ff      <= '0;
        end else if (wr_en) begin
            len_ff <= len_ff + (LAW+1)'(1); // RULE_04
            if (fill_ff) begin
                fill_ff    <= (fill_ch_ff < fill_end_ff);
                fill_ch_ff <= next_chan(fill_ch_ff);
            end
        end else if (len_full) begin
            fill_ff <= 1'b0;
        end
    end

    rss_list_mem #(.DEPTH(LIST_DEPTH), .AW(LAW), .DW(11)) u_list (
        .sys_clk (sys_clk),
        .wr_en   (wr_en),
        .wr_addr (len_ff[LAW-1:0]),
        .wr_data (wr_data),
        .rd_addr (pos_ff),
        .rd_data (list_rd)
    );

    // ----------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------
    logic [13:0] tick_cnt_ff;
    logic [13:0] cur_delay;
    logic [3:0]  cur_slot;
    logic        last_pos;
    assign cur_slot  = 4'(list_rd / 11'(`RSS_CH_PER_SLOT));
    assign cur_delay = (cur_slot >= 4'h1 && cur_slot <= 4'(SLOTS))
                       ? slot_delay_ff[cur_slot - 4'h1] : 14'h0;
    assign last_pos  = ((LAW+1)'(pos_ff) + (LAW+1)'(1) >= len_ff);

    // next channel is taken from registered list data two cycles after pos moves
    logic step_ff;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            step_ff <= 1'b0;
        end else begin
            step_ff <= (state_ff == RSS_CLOSE_WAIT) && !relay_close && !stop_req;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff    <= RSS_IDLE;
            pos_ff      <= '0;
            relay_close <= 1'b0;
            relay_chan  <= 11'h0;
            ready_pulse <= 1'b0;
            tick_cnt_ff <= 14'h0;
        end else if (stop_req) begin
            state_ff    <= RSS_IDLE; // RULE_13 RULE_18
            pos_ff      <= '0;
            relay_close <= 1'b0; // RULE_14
            ready_pulse <= 1'b0;
        end else begin
            unique case (state_ff)
                RSS_IDLE: begin
                    if (trig && len_ff != '0 && !fill_ff) begin
                        relay_chan  <= list_rd; // RULE_07 RULE_10
                        relay_close <= 1'b1;
                        state_ff    <= RSS_CLOSE_WAIT;
                    end
                end
                RSS_CLOSE_WAIT: begin
                    // a stale closed indication of the old channel is not taken
                    if (!relay_close && step_ff) begin
                        relay_chan  <= list_rd; // RULE_08
                        relay_close <= 1'b1;
                    end else if (relay_close && relay_closed) begin
                        tick_cnt_ff <= 14'h0; // RULE_20
                        state_ff    <= RSS_SETTLE;
                    end
                end
                RSS_SETTLE: begin
                    // one tick over the delay, so a free running tick never cuts it short
                    if (cur_delay == 14'h0 || tick_cnt_ff > cur_delay) begin
                        ready_pulse <= 1'b1; // RULE_01
                        tick_cnt_ff <= 14'h0;
                        state_ff    <= RSS_PULSE;
                    end else if (tick_ms) begin
                        tick_cnt_ff <= tick_cnt_ff + 14'h1;
                    end
                end
                RSS_PULSE, RSS_HOLD: begin
                    if (state_ff == RSS_PULSE && tick_ms) begin
                        tick_cnt_ff <= tick_cnt_ff + 14'h1;
                        if (tick_cnt_ff + 14'h1 >= 14'(pulse_w_ff)) begin
                            ready_pulse <= 1'b0; // RULE_11
                            state_ff    <= RSS_HOLD;
                        end
                    end
                    if (trig) begin
                        ready_pulse <= 1'b0; // RULE_12
                        if (last_pos) begin
                            relay_close <= 1'b0; // RULE_09
                            pos_ff      <= '0;
                            state_ff    <= RSS_IDLE;
                        end else begin
                            pos_ff      <= pos_ff + LAW'(1); // RULE_08
                            relay_close <= 1'b0;
                            state_ff    <= RSS_CLOSE_WAIT;
                        end
                    end
                end
            endcase
        end
    end


    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    AST_STOP_OPENS: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        stop_req |=> !relay_close && !ready_pulse && state_ff == RSS_IDLE) // RULE_14
        else $error("stop did not open relays");
    AST_REJECT: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        busy && (close_cmd || pulse_wr) |-> cmd_reject ##1 pulse_w_ff == $past(pulse_w_ff)) // RULE_15
        else $error("close command not rejected while scanning");
    AST_PULSE_END: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        ready_pulse && trig && !stop_req |=> !ready_pulse) // RULE_12
        else $error("ready pulse survived next step");
    AST_PULSE_ONLY_SETTLED: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        $rose(ready_pulse) |-> $past(state_ff) == RSS_SETTLE && relay_close) // RULE_01
        else $error("ready pulse without settled relay");
    AST_DEF_WIDTH: assert property (@(posedge sys_clk)
        $rose(rst_sync_n) |-> pulse_w_ff == 7'h05) // RULE_19
        else $error("pulse width default wrong");
    AST_WIDTH_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        pulse_w_ff >= 7'h01 && pulse_w_ff <= 7'h64) // RULE_11
        else $error("pulse width out of range");
    AST_RANGE_STEP: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        wr_en && fill_ff |=> fill_ch_ff != $past(fill_ch_ff)) // RULE_03
        else $error("range fill stalled");
    AST_EDGE_ONE: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        done_rise && !stop_req && (state_ff == RSS_PULSE || state_ff == RSS_HOLD) && !last_pos
        |=> pos_ff == $past(pos_ff) + LAW'(1)) // RULE_21
        else $error("edge counted twice");
    COV_START: cover property (@(posedge sys_clk) state_ff == RSS_IDLE && trig && len_ff != '0);
    COV_PULSE: cover property (@(posedge sys_clk) $rose(ready_pulse));
    COV_WRAP: cover property (@(posedge sys_clk) state_ff == RSS_HOLD && trig && last_pos);
    COV_ABORT: cover property (@(posedge sys_clk) busy && abort_cmd);
endmodule : rss_scan_seq

// ===== verification/rss_instr_model.sv
// instrument model that answers each ready pulse with measure done
`timescale 1ns/100ps
module rss_instr_model #(
    parameter int MEAS_CYC = 40
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // external io port
    input  wire logic ready_pulse,
    output logic      measure_done,
    // bench control
    input  wire logic auto_en,
    input  wire logic kick
);
    // ----------------------------------------
    // external trigger measurement
    // ----------------------------------------
    logic rp_ff;
    int   cnt_ff;

    // measuring takes longer than the pulse, so the pulse ends on its own
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_ff        <= 1'b0;
            cnt_ff       <= 0;
            measure_done <= 1'b0;
        end else begin
            rp_ff <= ready_pulse;
            if (kick || (auto_en && ready_pulse && !rp_ff)) begin
                cnt_ff <= kick ? MEAS_CYC : 1;
            end else if (cnt_ff != 0) begin
                cnt_ff <= (cnt_ff == MEAS_CYC + 4) ? 0 : cnt_ff + 1;
            end
            measure_done <= (cnt_ff >= MEAS_CYC);
        end
    end
endmodule : rss_instr_model

// ===== verification/rss_scan_seq_tb.sv
// self-checking bench of the relay scan sequencer
`timescale 1ns/100ps
module rss_scan_seq_tb;
    logic        sys_clk, rst_n, scan_reset, ready_pulse, trig_cmd, abort_cmd;
    logic        range_load, list_clear, list_append, delay_wr, pulse_wr;
    logic        close_cmd, cfg_cmd, cmd_reject, relay_close, relay_closed;
    logic        scan_active, measure_done, auto_en, kick, rej;
    logic        rc_q = 1'b0;
    logic [10:0] range_start, range_end, list_chan, relay_chan;
    logic [10:0] ch_q = 11'h0;
    logic [13:0] delay_ms;
    logic [6:0]  pulse_ms, list_len;
    logic [3:0]  delay_slot;
    logic [2:0]  rly_sh = 3'h0;
    logic [10:0] chans[$];
    logic [10:0] lst[3] = '{11'h131, 11'h066, 11'h453};
    int          errors, n_compared, n;
    int          cyc = 0, w_cnt = 0, last_w = 0;

    rss_scan_seq #(.TICK_CYCLES(10)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .measure_done(measure_done),
        .scan_reset(scan_reset), .ready_pulse(ready_pulse), .trig_cmd(trig_cmd),
        .abort_cmd(abort_cmd), .range_load(range_load), .range_start(range_start),
        .range_end(range_end), .list_clear(list_clear), .list_append(list_append),
        .list_chan(list_chan), .delay_wr(delay_wr), .delay_slot(delay_slot),
        .delay_ms(delay_ms), .pulse_wr(pulse_wr), .pulse_ms(pulse_ms),
        .close_cmd(close_cmd), .cfg_cmd(cfg_cmd), .cmd_reject(cmd_reject),
        .relay_close(relay_close), .relay_chan(relay_chan),
        .relay_closed(relay_closed), .scan_active(scan_active), .list_len(list_len)
    );

    rss_instr_model u_instr (
        .sys_clk(sys_clk), .rst_n(rst_n), .ready_pulse(ready_pulse),
        .measure_done(measure_done), .auto_en(auto_en), .kick(kick)
    );

    // ----------------------------------------
    // relay, monitors and watchdog
    // ----------------------------------------
    // relay confirms three cycles after closing and drops one cycle after it is opened
    assign relay_closed = rly_sh[2];

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        rly_sh <= relay_close ? {rly_sh[1:0], 1'b1} : 3'h0;
        rc_q <= relay_close;
        ch_q <= relay_chan;
        if (relay_close && (!rc_q || relay_chan != ch_q)) chans.push_back(relay_chan);
        w_cnt <= ready_pulse ? w_cnt + 1 : 0;
        if (!ready_pulse && w_cnt != 0) last_w <= w_cnt;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0d expected %0d", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : settle

    // one-cycle command strobe with its data; the reject flag is sampled meanwhile
    task automatic hit(input int k, input logic [13:0] d1 = 14'h0,
                       input logic [13:0] d2 = 14'h0);
        @(posedge sys_clk);
        range_start <= d1[10:0];
        range_end   <= d2[10:0];
        list_chan   <= d1[10:0];
        delay_slot  <= d1[3:0];
        delay_ms    <= d2;
        pulse_ms    <= d1[6:0];
        case (k)
            0: trig_cmd <= 1'b1;
            1: abort_cmd <= 1'b1;
            2: range_load <= 1'b1;
            3: list_clear <= 1'b1;
            4: list_append <= 1'b1;
            5: delay_wr <= 1'b1;
            6: pulse_wr <= 1'b1;
            7: close_cmd <= 1'b1;
            8: cfg_cmd <= 1'b1;
            default: scan_reset <= 1'b1;
        endcase
        #1;
        rej = cmd_reject;
        @(posedge sys_clk);
        {trig_cmd, abort_cmd, range_load, list_clear, list_append} <= '0;
        {delay_wr, pulse_wr, close_cmd, cfg_cmd, scan_reset} <= '0;
        #1;
    endtask : hit

    task automatic wait_sig(input int s, input logic v, output int c);
        c = 0;
        while ((s == 0 ? ready_pulse : s == 1 ? relay_close : scan_active) !== v
               && c < 3000) begin
            settle(1);
            c++;
        end
        if (c == 3000) check(0, 1);
    endtask : wait_sig

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rst_n, scan_reset, trig_cmd, abort_cmd, range_load, list_clear} = '0;
        {list_append, delay_wr, pulse_wr, close_cmd, cfg_cmd, auto_en, kick} = '0;
        {range_start, range_end, list_chan, delay_ms, pulse_ms} = '0;
        delay_slot = 4'h0;
        errors = 0;
        n_compared = 0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(5);
        check(relay_close, 0);
        check(ready_pulse | scan_active, 0);
        check(list_len, 0);
        // range scan stepped by command, slot delay 3 ms
        hit(5, 14'h2, 14'h3);
        hit(2, 14'h0C9, 14'h0CC);
        settle(10);
        check(list_len, 4);
        hit(6, 14'h65);
        chans.delete();
        hit(0);
        wait_sig(0, 1'b1, n);
        check(n >= 30 && n <= 55, 1);
        wait_sig(0, 1'b0, n);
        settle(1);
        check(last_w >= 40 && last_w <= 51, 1);
        for (int i = 0; i < 4; i++) begin
            hit(0);
            wait_sig(0, 1'b0, n);
            check(n <= 4, 1);
            if (i < 3) wait_sig(0, 1'b1, n);
        end
        settle(2);
        check(scan_active, 0);
        check(relay_close, 0);
        check(chans.size(), 4);
        for (int i = 0; i < 4; i++) check(chans[i], 11'h0C9 + i);
        hit(0);
        wait_sig(0, 1'b1, n);
        check(relay_chan, 11'h0C9);
        for (int k = 2; k < 9; k++) begin
            hit(k, 14'h2, 14'h3);
            check(rej, 1);
        end
        check(list_len, 4);
        hit(1);
        settle(1);
        check(scan_active | relay_close, 0);
        hit(0);
        wait_sig(1, 1'b1, n);
        check(relay_chan, 11'h0C9);
        hit(9);
        settle(1);
        check(scan_active | relay_close, 0);
        @(posedge sys_clk);
        kick <= 1'b1;
        @(posedge sys_clk);
        kick <= 1'b0;
        wait_sig(1, 1'b1, n);
        check(n <= 15, 1);
        check(relay_chan, 11'h0C9);
        hit(1);
        hit(8);
        check(rej, 0);
        $display("test range scan done");
        // explicit list stepped by the instrument, pulse 2 ms
        hit(3);
        settle(2);
        check(list_len, 0);
        for (int i = 0; i < 3; i++) hit(4, {3'h0, lst[i]});
        hit(6, 14'h2);
        settle(2);
        check(list_len, 3);
        @(posedge sys_clk);
        auto_en <= 1'b1;
        chans.delete();
        hit(0);
        wait_sig(2, 1'b0, n);
        check(chans.size(), 3);
        for (int i = 0; i < 3; i++) check(chans[i], lst[i]);
        check(last_w >= 10 && last_w <= 21, 1);
        check(relay_close, 0);
        $display("test explicit list done");
        summarize();
    end
endmodule : rss_scan_seq_tb
